// file: inc/ioc_pkg.sv
// constants for the internal oscillator control block: register offsets,
// field positions, reset values, timing counts and the enable state codes.
// assumes a 10 MHz system clock and a byte-addressed 32-bit register port.
package ioc_pkg;

  // register byte offsets on the register port
  localparam logic [7:0] ADDR_ULP_CTRL = 8'h1C; // ultra_low_power_32k_osc trim
  localparam logic [7:0] ADDR_RC8M_CTRL = 8'h20; // rc8m_osc_control
  localparam logic [7:0] ADDR_FLL_CTRL = 8'h24; // fll48_control
  localparam logic [7:0] ADDR_STATUS = 8'h40; // live oscillator state

  // rc8m_osc_control field positions
  localparam int RC8M_BAND_LSB = 30;
  localparam int RC8M_TRIM_LSB = 16;
  localparam int RC8M_DIV_LSB = 8;
  localparam int RC8M_OND_BIT = 7;
  localparam int RC8M_KAS_BIT = 6;
  localparam int RC8M_EN_BIT = 1;

  // ultra_low_power_32k_osc trim field
  localparam int ULP_TRIM_LSB = 0;

  // fll_control_reg field positions
  localparam int FLL_QLOFF_BIT = 9;
  localparam int FLL_CCOFF_BIT = 8;
  localparam int FLL_OND_BIT = 7;
  localparam int FLL_KAS_BIT = 6;
  localparam int FLL_DROP_BIT = 4;
  localparam int FLL_EN_BIT = 1;
  localparam logic [15:0] FLL_WMASK = 16'h03D2; // bits that really store
  localparam logic [15:0] FLL_RST = 16'h0080;

  // status register bit positions
  localparam int STAT_RC8M_RUN = 0;
  localparam int STAT_RC8M_READY = 1;
  localparam int STAT_FLL_RUN = 2;
  localparam int STAT_FLL_BUSY = 3;

  // rc8m reset values
  localparam logic [1:0] RC8M_DIV_RST = 2'h3;
  localparam logic RC8M_OND_RST = 1'b1;
  localparam logic RC8M_KAS_RST = 1'b0;
  localparam logic RC8M_EN_RST = 1'b1;

  // clock source codes used by each requester
  localparam int NUM_REQ = 8;
  localparam logic [1:0] SRC_RC8M = 2'h1;
  localparam logic [1:0] SRC_FLL = 2'h2;

  // timing: start-up and shut-down settle times of the rc8m, in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int RC8M_START_NS = 1000;
  localparam int RC8M_STOP_NS = 500;
  localparam logic [7:0] RC8M_START_CYC =
    8'((RC8M_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RC8M_STOP_CYC =
    8'((RC8M_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // cycles for a loop control write to reach the loop logic
  localparam logic [2:0] FLL_SYNC_CYC = 3'h3;

  // enable handshake states of the rc8m
  typedef enum logic [3:0] {
    IOC_OFF = 4'h1,
    IOC_START = 4'h2,
    IOC_ON = 4'h4,
    IOC_STOP = 4'h8
  } ioc_osc_st_t;

endpackage

// file: rtl/ioc_osc_ctrl.sv
// oscillator control registers: rc8m oscillator, ultra low power 32k trim
// and the loop control of the 48 MHz frequency locked loop.
// assumes register port, requests, standby and trim inputs all come from
// logic on mclk_i; the trim inputs are stable from reset release onward.
//
// How it works
// - two-bit band field picks rc8m frequency band
// - twelve-bit trim: temperature high, process low
// - trims and band loaded from calibration after reset
// - divider field sets rc8m division by 1,2,4,8
// - on-request mode runs oscillator only when requested
// - otherwise enabled oscillator runs all the time
// - keep-alive zero stops rc8m in standby
// - keep-alive one keeps normal gating in standby
// - rc8m enable reads back handshake status
// - loop writes delayed before use, write-protected
// - quick lock used unless disabled
// - chill cycles used unless disabled
// - drop locks on wake if loop stopped
// - loop uses same request gating and standby rule
// - loop enable reads back written value at once
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module ioc_osc_ctrl (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic wprot_i,
  input wire logic standby_i,
  input wire logic [7:0] clk_req_i,
  input wire logic [15:0] clk_src_i,
  input wire logic [1:0] nvm_band_i,
  input wire logic [11:0] nvm_rc8m_trim_i,
  input wire logic [4:0] nvm_ulp_trim_i,
  output logic rc8m_run_o,
  output logic [1:0] rc8m_band_o,
  output logic [11:0] rc8m_trim_o,
  output logic [3:0] rc8m_div_o,
  output logic [4:0] ulp_trim_o,
  output logic fll_run_o,
  output logic fll_quick_lock_o,
  output logic fll_chill_cycle_o,
  output logic fll_drop_lock_o
);

  // OR of requests from every requester whose source code matches
  // a requester that points at no oscillator (code 0 or 3) is ignored;
  // the loop runs over all requesters, so NUM_REQ must match the port
  function automatic logic req_for(input logic [7:0] req,
                                   input logic [15:0] src,
                                   input logic [1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < ioc_pkg::NUM_REQ; i++) begin
      hit = hit | (req[i] & (src[2*i +: 2] == code));
    end
    return hit;
  endfunction

  // run gate shared by the rc8m and the loop
  // standby forces the gate low only when keep-alive is zero; with
  // keep-alive one the normal on-request rule carries on in sleep
  function automatic logic run_gate(input logic on_req,
                                    input logic keep_alive,
                                    input logic req,
                                    input logic standby);
    logic g;
    g = on_req ? req : 1'b1;
    if (standby && !keep_alive) begin
      g = 1'b0;
    end
    return g;
  endfunction

  // division ratio as a one-hot count of the divider code
  // the oscillator clock itself is analog, so only the ratio leaves
  // the block; the divider proper sits next to the oscillator
  function automatic logic [3:0] div_ratio(input logic [1:0] code);
    return 4'h1 << code;
  endfunction

  // stored fields
  // band and trims start at zero and are overwritten by the load in
  // the first cycle after release, so zero is never seen for long
  logic load_r; // high for the first cycle after reset release
  logic [1:0] band_r;
  logic [11:0] trim8_r;
  logic [4:0] ulp_trim_r;
  logic [1:0] div_r;
  logic ond8_r;
  logic kas8_r;
  logic en8_r; // software target, not the status seen on read
  ioc_pkg::ioc_osc_st_t st_r;
  ioc_pkg::ioc_osc_st_t st_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [15:0] fll_sw_r; // value software reads back
  logic [15:0] fll_eff_r; // value the loop logic acts on
  logic [2:0] sync_cnt_r;
  logic standby_d_r;
  logic slept_stop_r; // loop was stopped at some point of this sleep
  logic [31:0] rdata_r;
  logic rc8m_run_r;
  logic fll_run_r;
  logic drop_r;
  // registered copies of decoded outputs, so that no output passes
  // through gates after its flip-flop
  logic [3:0] div_o_r; // one-hot ratio, follows the divider code
  logic qlk_r; // quick lock in use, from the acting loop copy
  logic chill_r; // chill cycles in use, from the acting loop copy

  // access decode; protection blocks every write
  // a blocked write is dropped silently; software gets no error and
  // must read back if it needs to know
  wire wr_ok = wr_i & ~wprot_i;
  wire wr_ulp = wr_ok & (addr_i == ioc_pkg::ADDR_ULP_CTRL);
  wire wr_rc8m = wr_ok & (addr_i == ioc_pkg::ADDR_RC8M_CTRL);
  wire wr_fll = wr_ok & (addr_i == ioc_pkg::ADDR_FLL_CTRL);

  // per-source request lines
  // requests are taken as same-clock signals; a requester in another
  // domain must be synchronised before it reaches clk_req_i
  wire req8 = req_for(clk_req_i, clk_src_i, ioc_pkg::SRC_RC8M);
  wire reqf = req_for(clk_req_i, clk_src_i, ioc_pkg::SRC_FLL);

  // status view of the rc8m enable: one while on or still stopping
  // status and run differ through each start-up and shut-down; the run
  // output also lags the state by one cycle
  wire en8_stat = (st_r == ioc_pkg::IOC_ON) | (st_r == ioc_pkg::IOC_STOP);
  wire osc8_on = (st_r == ioc_pkg::IOC_START) | (st_r == ioc_pkg::IOC_ON);

  // next values of the registered outputs
  // the loop gate acts on the delayed copy, so a write that enables
  // the loop only takes effect once the delay has run out
  wire rc8m_run_nxt = osc8_on & run_gate(ond8_r, kas8_r, req8, standby_i);
  wire fll_run_nxt = fll_eff_r[ioc_pkg::FLL_EN_BIT] &
    run_gate(fll_eff_r[ioc_pkg::FLL_OND_BIT],
             fll_eff_r[ioc_pkg::FLL_KAS_BIT], reqf, standby_i);
  // the pulse lasts one cycle; the loop logic must latch it
  wire wake = standby_d_r & ~standby_i;
  wire drop_nxt = wake & slept_stop_r &
    fll_eff_r[ioc_pkg::FLL_DROP_BIT];
  // the clear at wake wins over a stop seen in this cycle
  wire slept_stop_nxt = standby_i & (slept_stop_r | ~fll_run_r);

  // read views of each register
  // unused bits read as zero; the enable bit of the rc8m shows the
  // handshake status and never the target written
  wire [31:0] rc8m_view = {band_r, 2'h0, trim8_r, 6'h00, div_r, ond8_r,
                           kas8_r, 4'h0, en8_stat, 1'b0};
  wire [31:0] ulp_view = {27'h0000000, ulp_trim_r};
  wire [31:0] fll_view = {16'h0000, fll_sw_r};
  wire [31:0] stat_view = {28'h0000000, (sync_cnt_r != 3'h0), fll_run_r,
                           (st_r == ioc_pkg::IOC_ON), rc8m_run_r};
  wire [31:0] rd_val =
    (addr_i == ioc_pkg::ADDR_RC8M_CTRL) ? rc8m_view :
    (addr_i == ioc_pkg::ADDR_ULP_CTRL) ? ulp_view :
    (addr_i == ioc_pkg::ADDR_FLL_CTRL) ? fll_view :
    (addr_i == ioc_pkg::ADDR_STATUS) ? stat_view : 32'h00000000;

  // one-cycle pulse after release triggers the calibration load
  // load_r is set by reset, so no extra state is needed to find the
  // first edge after release
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_r <= 1'b1;
    end else begin
      load_r <= 1'b0;
    end
  end

  // band and trims: calibration load wins over a write in the same cycle
  // a write that meets the load is lost; software must not write in the
  // very first cycle after release
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      band_r <= 2'h0;
      trim8_r <= 12'h000;
      ulp_trim_r <= 5'h00;
    end else if (load_r) begin
      band_r <= nvm_band_i;
      trim8_r <= nvm_rc8m_trim_i;
      ulp_trim_r <= nvm_ulp_trim_i;
    end else begin
      if (wr_rc8m) begin
        band_r <= wdata_i[ioc_pkg::RC8M_BAND_LSB +: 2];
        trim8_r <= wdata_i[ioc_pkg::RC8M_TRIM_LSB +: 12];
      end
      if (wr_ulp) begin
        ulp_trim_r <= wdata_i[ioc_pkg::ULP_TRIM_LSB +: 5];
      end
    end
  end

  // rc8m control bits written by software
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= ioc_pkg::RC8M_DIV_RST;
      ond8_r <= ioc_pkg::RC8M_OND_RST;
      kas8_r <= ioc_pkg::RC8M_KAS_RST;
      en8_r <= ioc_pkg::RC8M_EN_RST;
      // ratio of the reset divider code, so the output is right at once
      div_o_r <= 4'h1 << ioc_pkg::RC8M_DIV_RST;
    end else if (wr_rc8m) begin
      // the ratio is decoded from the written code, not from div_r, so
      // that it changes on the same edge as the stored field
      div_o_r <= div_ratio(wdata_i[ioc_pkg::RC8M_DIV_LSB +: 2]);
      div_r <= wdata_i[ioc_pkg::RC8M_DIV_LSB +: 2];
      ond8_r <= wdata_i[ioc_pkg::RC8M_OND_BIT];
      kas8_r <= wdata_i[ioc_pkg::RC8M_KAS_BIT];
      en8_r <= wdata_i[ioc_pkg::RC8M_EN_BIT];
    end
  end

  // enable handshake: a transition always runs to its end; a target change
  // made meanwhile is picked up only afterwards, which is why software is
  // expected to poll the status first
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
    unique case (st_r)
      ioc_pkg::IOC_OFF: begin
        if (en8_r) begin
          st_nxt = ioc_pkg::IOC_START;
          cnt_nxt = ioc_pkg::RC8M_START_CYC - 8'h01;
        end
      end
      ioc_pkg::IOC_START: begin
        if (cnt_r == 8'h00) begin
          st_nxt = ioc_pkg::IOC_ON;
        end
      end
      ioc_pkg::IOC_ON: begin
        if (!en8_r) begin
          st_nxt = ioc_pkg::IOC_STOP;
          cnt_nxt = ioc_pkg::RC8M_STOP_CYC - 8'h01;
        end
      end
      ioc_pkg::IOC_STOP: begin
        if (cnt_r == 8'h00) begin
          st_nxt = ioc_pkg::IOC_OFF;
        end
      end
      default: begin
        // illegal one-hot code: fall back to off
        st_nxt = ioc_pkg::IOC_OFF;
        cnt_nxt = 8'h00;
      end
    endcase
  end

  // handshake state; enable resets to one, so the oscillator starts on
  // a glitch into an illegal code is caught by the default branch
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= ioc_pkg::IOC_ON;
      cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // loop control: read-back copy updates at once, the acting copy only
  // after the delay; a new write restarts the delay
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fll_sw_r <= ioc_pkg::FLL_RST;
      fll_eff_r <= ioc_pkg::FLL_RST;
      sync_cnt_r <= 3'h0;
      // both features are in use while their disable bits reset to zero
      qlk_r <= ~ioc_pkg::FLL_RST[ioc_pkg::FLL_QLOFF_BIT];
      chill_r <= ~ioc_pkg::FLL_RST[ioc_pkg::FLL_CCOFF_BIT];
    end else begin
      if (wr_fll) begin
        fll_sw_r <= wdata_i[15:0] & ioc_pkg::FLL_WMASK;
        sync_cnt_r <= ioc_pkg::FLL_SYNC_CYC;
      end else if (sync_cnt_r != 3'h0) begin
        sync_cnt_r <= sync_cnt_r - 3'h1;
      end
      if (!wr_fll && sync_cnt_r == 3'h1) begin
        fll_eff_r <= fll_sw_r;
        // feature outputs switch on the same edge as the acting copy
        qlk_r <= ~fll_sw_r[ioc_pkg::FLL_QLOFF_BIT];
        chill_r <= ~fll_sw_r[ioc_pkg::FLL_CCOFF_BIT];
      end
    end
  end

  // sleep tracking for the lock-drop pulse
  // standby_d_r starts low, so leaving reset in standby gives no
  // false wake pulse
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      standby_d_r <= 1'b0;
      slept_stop_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      standby_d_r <= standby_i;
      slept_stop_r <= slept_stop_nxt;
      drop_r <= drop_nxt;
    end
  end

  // oscillator run outputs
  // both run outputs are low in reset; the rc8m comes back one edge
  // after release if its gate allows
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc8m_run_r <= 1'b0;
      fll_run_r <= 1'b0;
    end else begin
      rc8m_run_r <= rc8m_run_nxt;
      fll_run_r <= fll_run_nxt;
    end
  end

  // read data stand only in the cycle after the strobe
  // zero outside the answer cycle keeps a wired-OR bus quiet
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rd_i ? rd_val : 32'h00000000;
    end
  end

  // every output straight from a flip-flop
  assign rdata_o = rdata_r;
  assign rc8m_run_o = rc8m_run_r;
  assign rc8m_band_o = band_r;
  assign rc8m_trim_o = trim8_r;
  assign rc8m_div_o = div_o_r;
  assign ulp_trim_o = ulp_trim_r;
  assign fll_run_o = fll_run_r;
  assign fll_quick_lock_o = qlk_r;
  assign fll_chill_cycle_o = chill_r;
  assign fll_drop_lock_o = drop_r;

endmodule

`default_nettype wire

// file: verification/ioc_osc_ctrl_assertions.sv
// port checker for the oscillator control block.
// assumes one clock domain on mclk_i, reset nrst_i, bound to ioc_osc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module ioc_osc_chk (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic wprot_i,
  input wire logic standby_i,
  input wire logic [7:0] clk_req_i,
  input wire logic [15:0] clk_src_i,
  input wire logic [1:0] nvm_band_i,
  input wire logic [11:0] nvm_rc8m_trim_i,
  input wire logic [4:0] nvm_ulp_trim_i,
  input wire logic rc8m_run_o,
  input wire logic [1:0] rc8m_band_o,
  input wire logic [11:0] rc8m_trim_o,
  input wire logic [3:0] rc8m_div_o,
  input wire logic [4:0] ulp_trim_o,
  input wire logic fll_run_o,
  input wire logic fll_quick_lock_o,
  input wire logic fll_chill_cycle_o,
  input wire logic fll_drop_lock_o
);
  logic [15:0] fll_r; // shadow of the loop control word
  logic [3:0] r8_r; // shadow of rc8m divider, on-request, keep-alive
  logic [1:0] rel_r; // edges since reset release, saturating
  logic req8; // some requester asks for the rc8m
  wire wok = wr_i && !wprot_i; // a write that really lands
  // requests only count when the requester selects the rc8m
  always_comb begin
    req8 = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (clk_req_i[i] && clk_src_i[2*i +: 2] == ioc_pkg::SRC_RC8M)
        req8 = 1'b1;
    end
  end
  // shadows follow landed writes in the same cycle as the design
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fll_r <= ioc_pkg::FLL_RST;
      r8_r <= 4'hE;
      rel_r <= 2'h0;
    end else begin
      if (rel_r != 2'h3)
        rel_r <= rel_r + 2'h1;
      if (wok && addr_i == ioc_pkg::ADDR_FLL_CTRL)
        fll_r <= wdata_i[15:0] & ioc_pkg::FLL_WMASK;
      if (wok && addr_i == ioc_pkg::ADDR_RC8M_CTRL)
        r8_r <= wdata_i[9:6];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_fll_read_back: assert property (
    rd_i && addr_i == ioc_pkg::ADDR_FLL_CTRL |=>
    rdata_o == {16'h0, $past(fll_r)}) else $error("loop readback wrong");
  a_quick_lock_use: assert property (
    wok && addr_i == ioc_pkg::ADDR_FLL_CTRL ##1
    (!(wr_i && addr_i == ioc_pkg::ADDR_FLL_CTRL))[*6] |->
    fll_quick_lock_o == !fll_r[9]) else $error("quick lock wrong");
  a_chill_cycle_use: assert property (
    wok && addr_i == ioc_pkg::ADDR_FLL_CTRL ##1
    (!(wr_i && addr_i == ioc_pkg::ADDR_FLL_CTRL))[*6] |->
    fll_chill_cycle_o == !fll_r[8]) else $error("chill cycle wrong");
  a_stby_stops_rc8m: assert property (
    standby_i && !r8_r[0] |=> !rc8m_run_o) else $error("runs in standby");
  a_run_on_request_gate: assert property (
    r8_r[1] && !req8 |=> !rc8m_run_o) else $error("runs unrequested");
  a_div_ratio: assert property (
    r8_r == $past(r8_r) |-> rc8m_div_o == 4'h1 << r8_r[3:2])
    else $error("divider ratio wrong");
  a_cal_load: assert property (
    rel_r == 2'h2 |-> rc8m_band_o == nvm_band_i &&
    rc8m_trim_o == nvm_rc8m_trim_i && ulp_trim_o == nvm_ulp_trim_i)
    else $error("calibration not loaded");
  a_trim_write: assert property (
    wok && addr_i == ioc_pkg::ADDR_RC8M_CTRL ##1 !wr_i |=>
    rc8m_trim_o == $past(wdata_i[27:16], 2) &&
    rc8m_band_o == $past(wdata_i[31:30], 2)) else $error("trim wrong");
  a_drop_pulse: assert property (
    fll_drop_lock_o |-> fll_r[4] && ($past(standby_i) ||
    $past(standby_i, 2)) ##1 !fll_drop_lock_o) else $error("bad drop");
  c_drop: cover property (fll_drop_lock_o);
  c_stby_run: cover property (standby_i && rc8m_run_o);
  c_fll_read: cover property (rd_i && addr_i == ioc_pkg::ADDR_FLL_CTRL);
endmodule
bind ioc_osc_ctrl ioc_osc_chk chk_u (.mclk_i, .nrst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .wprot_i, .standby_i, .clk_req_i, .clk_src_i,
  .nvm_band_i, .nvm_rc8m_trim_i, .nvm_ulp_trim_i, .rc8m_run_o,
  .rc8m_band_o, .rc8m_trim_o, .rc8m_div_o, .ulp_trim_o, .fll_run_o,
  .fll_quick_lock_o, .fll_chill_cycle_o, .fll_drop_lock_o);
`default_nettype wire

// file: verification/ioc_osc_ctrl_bench.sv
// self-checking bench for the oscillator control block.
// assumes a 10 MHz clock and the one-cycle register port.
`timescale 1ns/10ps
`default_nettype none
module ioc_osc_ctrl_bench;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, wprot_i = 1'b0, standby_i = 1'b0;
  logic [7:0] clk_req_i = 8'h00;
  logic [15:0] clk_src_i = 16'h0000, s, e;
  logic [1:0] nvm_band_i, rc8m_band_o;
  logic [11:0] nvm_rc8m_trim_i, rc8m_trim_o;
  logic [4:0] nvm_ulp_trim_i, ulp_trim_o;
  logic [31:0] rdata_o, d, w;
  logic [3:0] rc8m_div_o;
  logic rc8m_run_o, fll_run_o, fll_quick_lock_o, fll_chill_cycle_o;
  logic fll_drop_lock_o;
  int bad_count = 0;
  int total_checks = 0;
  int k;
  ioc_osc_ctrl dut_u (.mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .wprot_i, .standby_i, .clk_req_i, .clk_src_i, .nvm_band_i,
    .nvm_rc8m_trim_i, .nvm_ulp_trim_i, .rc8m_run_o, .rc8m_band_o,
    .rc8m_trim_o, .rc8m_div_o, .ulp_trim_o, .fll_run_o, .fll_quick_lock_o,
    .fll_chill_cycle_o, .fll_drop_lock_o);
  initial forever #50 mclk_i = ~mclk_i;
  // one compare for every result, widened to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // let n edges land, then look once things have settled
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // bounded wait on the enable status; running out ends the run
  task automatic poll(input logic v);
    for (int i = 0; i < 20; i++) begin
      rd(ioc_pkg::ADDR_RC8M_CTRL, d);
      if (d[1] === v)
        return;
    end
    chk({31'h0, d[1]}, {31'h0, v});
    close_out();
  endtask
  initial begin
    void'($urandom(58));
    nvm_band_i = 2'($urandom);
    nvm_rc8m_trim_i = 12'($urandom);
    nvm_ulp_trim_i = 5'($urandom);
    settle(12);
    nrst_i <= 1'b1;
    settle(4);
    rd(ioc_pkg::ADDR_RC8M_CTRL, d);
    chk(d, {nvm_band_i, 2'h0, nvm_rc8m_trim_i, 16'h0382});
    rd(ioc_pkg::ADDR_FLL_CTRL, d);
    chk(d, 32'h0000_0080);
    rd(ioc_pkg::ADDR_ULP_CTRL, d);
    chk(d, {27'h0, nvm_ulp_trim_i});
    rd(8'h30, d);
    chk(d, 32'h0);
    // the loaded low power trim stays writable by software
    w = $urandom;
    wr(ioc_pkg::ADDR_ULP_CTRL, w);
    rd(ioc_pkg::ADDR_ULP_CTRL, d);
    chk(d, {27'h0, w[4:0]});
    chk({27'h0, ulp_trim_o}, {27'h0, w[4:0]});
    // every band and divider code, random trim
    for (int c = 0; c < 4; c++) begin
      w = {c[1:0], 2'h0, 12'($urandom), 6'h0, c[1:0], 8'h82};
      wr(ioc_pkg::ADDR_RC8M_CTRL, w);
      rd(ioc_pkg::ADDR_RC8M_CTRL, d);
      chk(d, w);
      chk({28'h0, rc8m_div_o}, 32'h1 << c);
      chk({30'h0, rc8m_band_o}, c);
      chk({20'h0, rc8m_trim_o}, {20'h0, w[27:16]});
    end
    // one random requester on the rc8m, the rest on the loop
    k = $urandom_range(7);
    s = 16'hAAAA;
    s[2*k +: 2] = ioc_pkg::SRC_RC8M;
    clk_src_i <= s;
    clk_req_i <= 8'hFF ^ (8'h1 << k);
    settle(3);
    chk({31'h0, rc8m_run_o}, 32'h0);
    clk_req_i <= 8'h1 << k;
    settle(3);
    chk({31'h0, rc8m_run_o}, 32'h1);
    clk_req_i <= 8'h00;
    wr(ioc_pkg::ADDR_RC8M_CTRL, w & ~32'h80);
    settle(3);
    chk({31'h0, rc8m_run_o}, 32'h1);
    standby_i <= 1'b1;
    settle(3);
    chk({31'h0, rc8m_run_o}, 32'h0);
    wr(ioc_pkg::ADDR_RC8M_CTRL, (w & ~32'h80) | 32'h40);
    settle(3);
    chk({31'h0, rc8m_run_o}, 32'h1);
    standby_i <= 1'b0;
    // shutdown then startup, status seen mid-way each time
    wr(ioc_pkg::ADDR_RC8M_CTRL, (w & ~32'h82) | 32'h40);
    rd(ioc_pkg::ADDR_RC8M_CTRL, d);
    chk({31'h0, d[1]}, 32'h1);
    poll(1'b0);
    chk({31'h0, rc8m_run_o}, 32'h0);
    wr(ioc_pkg::ADDR_RC8M_CTRL, (w & ~32'h80) | 32'h40);
    rd(ioc_pkg::ADDR_RC8M_CTRL, d);
    chk({31'h0, d[1]}, 32'h0);
    poll(1'b1);
    chk({31'h0, rc8m_run_o}, 32'h1);
    rd(ioc_pkg::ADDR_STATUS, d);
    chk(d, 32'h0000_0003);
    // random loop words, one of them under write protection
    e = 16'h0080;
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      wprot_i <= (i == 5);
      wr(ioc_pkg::ADDR_FLL_CTRL, w);
      #1 chk({31'h0, fll_quick_lock_o}, {31'h0, ~e[9]});
      wprot_i <= 1'b0;
      if (i != 5)
        e = w[15:0] & ioc_pkg::FLL_WMASK;
      rd(ioc_pkg::ADDR_FLL_CTRL, d);
      chk(d, {16'h0, e});
      settle(6);
      chk({31'h0, fll_quick_lock_o}, {31'h0, ~e[9]});
      chk({31'h0, fll_chill_cycle_o}, {31'h0, ~e[8]});
    end
    // loop on request: idle, requested, then stopped by standby
    wr(ioc_pkg::ADDR_FLL_CTRL, 32'h0000_0082);
    settle(6);
    chk({31'h0, fll_run_o}, 32'h0);
    clk_req_i <= 8'hFF ^ (8'h1 << k);
    settle(3);
    chk({31'h0, fll_run_o}, 32'h1);
    standby_i <= 1'b1;
    settle(3);
    chk({31'h0, fll_run_o}, 32'h0);
    standby_i <= 1'b0;
    clk_req_i <= 8'h00;
    // sleep with the loop stopped, lock drop armed and not armed
    for (int b = 1; b >= 0; b--) begin
      wr(ioc_pkg::ADDR_FLL_CTRL, {27'h0, b[0], 4'h0});
      settle(6);
      standby_i <= 1'b1;
      settle(4);
      standby_i <= 1'b0;
      k = 0;
      repeat (5) begin
        settle(1);
        if (fll_drop_lock_o === 1'b1)
          k++;
      end
      chk(k, b);
    end
    close_out();
  end
endmodule
`default_nettype wire
